/* verilog/alu_pkg.sv */
// constants, register map and carrier types for the subtract datapath slice
package alu_pkg;

  // ----------------------------------------------------------------------
  // register map (byte offsets, one 32-bit word each)
  // ----------------------------------------------------------------------
  localparam int          REG_ADDR_W   = 5;
  localparam logic [4:0]  OFS_ACC      = 5'h00;
  localparam logic [4:0]  OFS_CTRL     = 5'h04;
  localparam logic [4:0]  OFS_PAGE     = 5'h08;
  localparam logic [4:0]  OFS_AUX      = 5'h0C;
  localparam logic [4:0]  OFS_IRQ_STAT = 5'h10;
  localparam logic [4:0]  OFS_IRQ_MASK = 5'h14;
  localparam logic [4:0]  OFS_STATE    = 5'h18;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_CARRY_BIT = 0;
  localparam int CTRL_WRAP_BIT  = 1;
  localparam int CTRL_SAT_BIT   = 2;
  localparam int CTRL_SXM_BIT   = 3;
  localparam int EVT_DONE_BIT   = 0;
  localparam int EVT_WRAP_BIT   = 1;
  localparam int EVT_ILL_BIT    = 2;
  localparam int EVT_W          = 3;
  localparam int INDIRECT_BIT   = 7;
  localparam int CONDITIONAL_SUBTRACT_STEP_SHIFT     = 15;

  // ----------------------------------------------------------------------
  // opcodes (upper byte of the instruction word) and fixed values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  OPC_SUBTRACT_WITH_BORROW     = 8'h4F;
  localparam logic [7:0]  OPC_CONDITIONAL_SUBTRACT_STEP     = 8'h47;
  localparam logic [31:0] SAT_POS      = 32'h7FFF_FFFF;
  localparam logic [31:0] SAT_NEG      = 32'h8000_0000;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] ACC_RST      = 32'h0000_0000;
  localparam logic [3:0]  CTRL_RST     = 4'h0;
  localparam logic [8:0]  PAGE_RST     = 9'h000;
  localparam logic [15:0] AUX_RST      = 16'h0000;
  localparam logic [2:0]  EVT_RST      = 3'h0;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC  = 2'b11
  } seq_state_t;

  typedef enum logic {
    OP_SUBTRACT_WITH_BORROW = 1'b0,
    OP_CONDITIONAL_SUBTRACT_STEP = 1'b1
  } op_t;

  // bit order matches the control register, carry in bit 0
  typedef struct packed {
    logic sign_extend_select;
    logic saturate_enable;
    logic arith_wrap_flag;
    logic carry;
  } flags_t;

  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [REG_ADDR_W-1:0] addr;
    logic [31:0]           wdata;
  } bus_req_t;

  typedef struct packed {
    logic        rd;
    logic [15:0] addr;
  } mem_req_t;

  typedef struct packed {
    logic [1:0]      rst_sync;
    seq_state_t      state;
    op_t             op;
    logic [31:0]     acc;
    flags_t          flags;
    logic [8:0]      page;
    logic [15:0]     aux;
    logic [EVT_W-1:0] irq_stat;
    logic [EVT_W-1:0] irq_mask;
    logic [31:0]     rdata;
    logic            irq;
    logic            ready;
    logic            done;
    mem_req_t        mem;
  } alu_state_t;

endpackage : alu_pkg

/* verilog/sub_unit.sv */
// width-parameterised subtractor with borrow in, carry out and signed overflow
`timescale 1ns/100ps
module sub_unit
  import alu_pkg::*;
#(
  parameter int W = 32
) (
  input  wire logic [W-1:0] minuend,     // left operand
  input  wire logic [W-1:0] subtrahend,  // right operand
  input  wire logic         borrow_in,   // one extra unit taken off
  output logic      [W-1:0] diff,        // wrapped difference
  output logic              carry_out,   // high when no borrow came out
  output logic              overflow     // signed overflow of the difference
);

  logic [W:0] wide;

  // one extra bit catches the borrow out of the top
  always_comb
  begin
    wide      = {1'b0, minuend} - {1'b0, subtrahend} - {{W{1'b0}}, borrow_in};
    diff      = wide[W-1:0];
    carry_out = ~wide[W];
    overflow  = (minuend[W-1] ^ subtrahend[W-1]) & (minuend[W-1] ^ wide[W-1]);
  end

endmodule : sub_unit

/* verilog/subtract_borrow_conditional_alu.sv */
// subtract-with-borrow and conditional-subtract datapath with register port
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/100ps
module subtract_borrow_conditional_alu
  import alu_pkg::*;
(
  input  wire logic        ref_clk,      // core clock, 100 MHz
  input  wire logic        rst_b,        // async reset, active low
  input  wire logic        clk_en,       // freezes all state but the reset pipe while low
  input  wire bus_req_t    bus_req,      // register port request
  output logic      [31:0] bus_rdata_q,  // read data, cycle after read strobe
  input  wire logic        instr_valid,  // instruction offered
  input  wire logic [15:0] instr_word,   // instruction word
  output logic             instr_ready_q, // idle, instruction may be taken
  output mem_req_t         mem_req_q,    // data memory read request
  input  wire logic [15:0] mem_rdata,    // operand, cycle after mem read
  output logic      [31:0] acc_q,        // accumulator
  output flags_t           flags_q,      // carry, wrap and mode bits
  output logic             done_q,       // one-cycle pulse per finished op
  output logic             irq_q         // level interrupt
);

  // --------------------------------------------------------------------
  // state and working signals
  // --------------------------------------------------------------------
  alu_state_t       s_q;
  alu_state_t       s_d;
  logic             rst_b_sync;
  logic [31:0]      opnd_zext;
  logic [31:0]      opnd_div;
  logic [31:0]      subtract_with_borrow_diff;
  logic             subtract_with_borrow_carry;
  logic             subtract_with_borrow_wrap;
  logic [31:0]      conditional_subtract_step_diff;
  logic             conditional_subtract_step_carry;
  logic             conditional_subtract_step_wrap;
  logic [EVT_W-1:0] events;
  logic [EVT_W-1:0] w1c_bits;
  logic [7:0]       opcode;
  logic             wr_acc;
  logic             wr_ctrl;

  // --------------------------------------------------------------------
  // reset release through two flops
  // --------------------------------------------------------------------
  // async assert, sync release; kept outside the state struct so the
  // struct register can use the released copy
  logic [1:0] rst_pipe_q;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_pipe_q <= 2'b00;
    else
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
  end

  assign rst_b_sync = rst_pipe_q[1];

  // --------------------------------------------------------------------
  // operand shaping
  // --------------------------------------------------------------------
  // borrow subtract treats the memory word as unsigned
  assign opnd_zext = {16'h0000, mem_rdata};

  // divisor follows the extension mode, then moves up by fifteen
  always_comb
  begin
    if (s_q.flags.sign_extend_select)
      opnd_div = {{16{mem_rdata[15]}}, mem_rdata} << CONDITIONAL_SUBTRACT_STEP_SHIFT;
    else
      opnd_div = {16'h0000, mem_rdata} << CONDITIONAL_SUBTRACT_STEP_SHIFT;
  end

  // --------------------------------------------------------------------
  // the two subtractors
  // --------------------------------------------------------------------
  // inverted carry is the pending borrow
  sub_unit #(
    .W (32)
  ) u_subtract_with_borrow (
    .minuend    (s_q.acc),
    .subtrahend (opnd_zext),
    .borrow_in  (~s_q.flags.carry),
    .diff       (subtract_with_borrow_diff),
    .carry_out  (subtract_with_borrow_carry),
    .overflow   (subtract_with_borrow_wrap)
  );

  sub_unit #(
    .W (32)
  ) u_conditional_subtract_step (
    .minuend    (s_q.acc),
    .subtrahend (opnd_div),
    .borrow_in  (1'b0),
    .diff       (conditional_subtract_step_diff),
    .carry_out  (conditional_subtract_step_carry),
    .overflow   (conditional_subtract_step_wrap)
  );

  // --------------------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------------------
  assign opcode  = instr_word[15:8];
  assign wr_acc  = bus_req.wr && (bus_req.addr == OFS_ACC);
  assign wr_ctrl = bus_req.wr && (bus_req.addr == OFS_CTRL);

  // write-one-to-clear mask for the status register
  always_comb
  begin
    w1c_bits = '0;
    if (bus_req.wr && (bus_req.addr == OFS_IRQ_STAT))
      w1c_bits = bus_req.wdata[EVT_W-1:0];
  end

  // --------------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------------
  always_comb
  begin
    s_d          = s_q;
    events       = '0;
    s_d.done     = 1'b0;
    s_d.mem.rd   = 1'b0;
    s_d.rdata    = 32'h0000_0000;

    // software writes first; execution below overrides the same cycle
    if (wr_acc)
      s_d.acc = bus_req.wdata;
    if (wr_ctrl)
      s_d.flags = flags_t'(bus_req.wdata[3:0]);
    if (bus_req.wr && (bus_req.addr == OFS_PAGE))
      s_d.page = bus_req.wdata[8:0];
    if (bus_req.wr && (bus_req.addr == OFS_AUX))
      s_d.aux = bus_req.wdata[15:0];
    if (bus_req.wr && (bus_req.addr == OFS_IRQ_MASK))
      s_d.irq_mask = bus_req.wdata[EVT_W-1:0];

    // instruction sequencer
    unique case (s_q.state)
      ST_IDLE:
      begin
        if (instr_valid)
        begin
          if ((opcode == OPC_SUBTRACT_WITH_BORROW) || (opcode == OPC_CONDITIONAL_SUBTRACT_STEP))
          begin
            s_d.op    = (opcode == OPC_CONDITIONAL_SUBTRACT_STEP) ? OP_CONDITIONAL_SUBTRACT_STEP : OP_SUBTRACT_WITH_BORROW;
            s_d.state = ST_FETCH;
            s_d.ready = 1'b0;
            s_d.mem.rd = 1'b1;
            // bit seven: pointer register, otherwise page plus offset
            if (instr_word[INDIRECT_BIT])
              s_d.mem.addr = s_q.aux;
            else
              s_d.mem.addr = {s_q.page, instr_word[6:0]};
          end
          else
          begin
            events[EVT_ILL_BIT] = 1'b1;  // unknown opcode dropped
          end
        end
      end
      ST_FETCH:
      begin
        // memory answers in the next cycle
        s_d.state = ST_EXEC;
      end
      ST_EXEC:
      begin
        s_d.state = ST_IDLE;
        s_d.ready = 1'b1;
        s_d.done  = 1'b1;
        events[EVT_DONE_BIT] = 1'b1;
        if (s_q.op == OP_SUBTRACT_WITH_BORROW)
        begin
          s_d.flags.carry = subtract_with_borrow_carry;
          if (subtract_with_borrow_wrap)
          begin
            s_d.flags.arith_wrap_flag = 1'b1;
            events[EVT_WRAP_BIT]      = 1'b1;
          end
          if (subtract_with_borrow_wrap && s_q.flags.saturate_enable)
            s_d.acc = s_q.acc[31] ? SAT_NEG : SAT_POS;
          else
            s_d.acc = subtract_with_borrow_diff;
        end
        else
        begin
          // no clamp here, whatever the saturation mode
          s_d.flags.carry = conditional_subtract_step_carry;
          if (conditional_subtract_step_wrap)
          begin
            s_d.flags.arith_wrap_flag = 1'b1;
            events[EVT_WRAP_BIT]      = 1'b1;
          end
          // quotient bits shift in at the bottom, remainder rises
          if (!conditional_subtract_step_diff[31])
            s_d.acc = {conditional_subtract_step_diff[30:0], 1'b1};
          else
            s_d.acc = {s_q.acc[30:0], 1'b0};
        end
      end
      default:
      begin
        s_d.state = ST_IDLE;
        s_d.ready = 1'b1;
      end
    endcase

    // sticky events: a new event wins over a clear in the same cycle
    s_d.irq_stat = (s_q.irq_stat & ~w1c_bits) | events;
    s_d.irq      = |(s_d.irq_stat & s_d.irq_mask);

    // read mux, data stands only in the cycle after the strobe
    if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        OFS_ACC:      s_d.rdata = s_q.acc;
        OFS_CTRL:     s_d.rdata = {28'h000_0000, s_q.flags};
        OFS_PAGE:     s_d.rdata = {23'h00_0000, s_q.page};
        OFS_AUX:      s_d.rdata = {16'h0000, s_q.aux};
        OFS_IRQ_STAT: s_d.rdata = {29'h0000_0000, s_q.irq_stat};
        OFS_IRQ_MASK: s_d.rdata = {29'h0000_0000, s_q.irq_mask};
        OFS_STATE:    s_d.rdata = {28'h000_0000, s_q.state, s_q.op, s_q.ready};
        default:      s_d.rdata = 32'h0000_0000;
      endcase
    end

    // rst_sync slot unused; pipe kept in its own flops
    s_d.rst_sync = 2'b00;
  end

  // --------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------
  // one register for the whole struct; clock enable freezes everything
  always_ff @(posedge ref_clk or negedge rst_b_sync)
  begin
    if (!rst_b_sync)
    begin
      s_q          <= '0;
      s_q.state    <= ST_IDLE;
      s_q.op       <= OP_SUBTRACT_WITH_BORROW;
      s_q.acc      <= ACC_RST;
      s_q.flags    <= flags_t'(CTRL_RST);
      s_q.page     <= PAGE_RST;
      s_q.aux      <= AUX_RST;
      s_q.irq_stat <= EVT_RST;
      s_q.irq_mask <= EVT_RST;
      s_q.ready    <= 1'b1;
    end
    else if (clk_en)
    begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------------
  // outputs, all straight from the state register
  // --------------------------------------------------------------------
  assign bus_rdata_q   = s_q.rdata;
  assign instr_ready_q = s_q.ready;
  assign mem_req_q     = s_q.mem;
  assign acc_q         = s_q.acc;
  assign flags_q       = s_q.flags;
  assign done_q        = s_q.done;
  assign irq_q         = s_q.irq;

endmodule : subtract_borrow_conditional_alu

/* dv/subtract_borrow_conditional_alu_props.sv */
// protocol checks for the subtract datapath slice
`timescale 1ns/100ps
module alu_props
  import alu_pkg::*;
(
  input wire logic        ref_clk,       // core clock
  input wire logic        rst_b,         // async reset, active low
  input wire logic        clk_en,        // state freeze while low
  input wire bus_req_t    bus_req,       // register request
  input wire logic [31:0] bus_rdata_q,   // register read data
  input wire logic        instr_valid,   // instruction offered
  input wire logic [15:0] instr_word,    // instruction word
  input wire logic        instr_ready_q, // idle
  input wire mem_req_t    mem_req_q,     // operand request
  input wire logic [15:0] mem_rdata,     // operand
  input wire logic [31:0] acc_q,         // accumulator
  input wire flags_t      flags_q,       // flags
  input wire logic        done_q,        // finish pulse
  input wire logic        irq_q          // interrupt
);
  // ----------------------------------------------------------------------
  // decode and sequences
  // ----------------------------------------------------------------------
  logic legal;

  // only two opcodes are executed, anything else is refused
  assign legal = (instr_word[15:8] == OPC_SUBTRACT_WITH_BORROW) || (instr_word[15:8] == OPC_CONDITIONAL_SUBTRACT_STEP);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_take;
    instr_ready_q && instr_valid && clk_en && legal;
  endsequence

  sequence s_exec;
    (mem_req_q.rd && !instr_ready_q) ##1 (!mem_req_q.rd && !instr_ready_q)
      ##1 (done_q && instr_ready_q);
  endsequence

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  chk_take_seq: assert property (s_take |=> s_exec)
    else $error("instruction sequence broken");
  chk_rdata_idle: assert property (!bus_req.rd |=> bus_rdata_q == 32'h0000_0000)
    else $error("read data outside its cycle");
  chk_done_pulse: assert property (done_q |=> !done_q)
    else $error("done longer than one cycle");
  chk_mem_pulse: assert property (mem_req_q.rd |=> !mem_req_q.rd)
    else $error("operand request longer than one cycle");
  chk_illegal_refused: assert property
    (instr_ready_q && instr_valid && clk_en && !legal |=> instr_ready_q && !mem_req_q.rd)
    else $error("illegal opcode executed");
  chk_busy_ignore: assert property (!instr_ready_q |=> !mem_req_q.rd)
    else $error("instruction taken while busy");
  chk_done_cause: assert property ($rose(done_q) |-> $past(mem_req_q.rd, 2))
    else $error("done without operand fetch");
  chk_freeze_state: assert property
    (!clk_en |=> $stable(acc_q) && $stable(flags_q) && $stable(irq_q))
    else $error("state moved while frozen");
endmodule : alu_props

bind subtract_borrow_conditional_alu alu_props u_props (
  .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .bus_req(bus_req),
  .bus_rdata_q(bus_rdata_q), .instr_valid(instr_valid), .instr_word(instr_word),
  .instr_ready_q(instr_ready_q), .mem_req_q(mem_req_q), .mem_rdata(mem_rdata),
  .acc_q(acc_q), .flags_q(flags_q), .done_q(done_q), .irq_q(irq_q)
);

/* dv/subtract_borrow_conditional_alu_test.sv */
// self-checking bench for the subtract datapath slice
`timescale 1ns/100ps
module subtract_borrow_conditional_alu_test
  import alu_pkg::*;
;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic        ref_clk, rst_b, clk_en, instr_valid, instr_ready_q, done_q, irq_q;
  bus_req_t    bus_req;
  mem_req_t    mem_req_q;
  flags_t      flags_q;
  logic [15:0] instr_word, mem_rdata, aux_v, dvd, dvs;
  logic [31:0] bus_rdata_q, acc_q, rd_v;
  logic [8:0]  page_v;
  logic [4:0]  ofs [7] = '{OFS_ACC, OFS_CTRL, OFS_PAGE, OFS_AUX, OFS_IRQ_STAT,
                           OFS_IRQ_MASK, 5'h1C};
  int          n_fail, tests_run, sh;

  subtract_borrow_conditional_alu uut (
    .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .bus_req(bus_req),
    .bus_rdata_q(bus_rdata_q), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready_q(instr_ready_q), .mem_req_q(mem_req_q), .mem_rdata(mem_rdata),
    .acc_q(acc_q), .flags_q(flags_q), .done_q(done_q), .irq_q(irq_q)
  );

  // free-running core clock
  always #5 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk) bus_req <= {1'b1, 1'b0, a, d};
    @(posedge ref_clk) bus_req <= '0;
  endtask : wr

  // data stands only in the cycle after the read edge
  task rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge ref_clk) bus_req <= {1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge ref_clk) bus_req <= '0;
    #1 d = bus_rdata_q;
  endtask : rd

  task setup(input logic [31:0] a, input logic [3:0] c);
    wr(OFS_ACC, a);
    wr(OFS_CTRL, {28'h000_0000, c});
  endtask : setup

  // expected {carry, wrap, acc}; wrap is sticky, the step never clamps
  function automatic logic [33:0] model(input logic [7:0] op, input logic [31:0] a,
                                        input logic [15:0] o, input flags_t f);
    logic [32:0] r, s;
    logic [31:0] e, d;
    logic        v;
    if (op == OPC_CONDITIONAL_SUBTRACT_STEP)
    begin
      e = f.sign_extend_select ? {{16{o[15]}}, o} : {16'h0000, o};
      d = e << CONDITIONAL_SUBTRACT_STEP_SHIFT;
      r = {1'b0, a} - {1'b0, d};
      s = {a[31], a} - {d[31], d};
      v = s[32] ^ s[31];
      return {!r[32], f.arith_wrap_flag | v, r[31] ? a << 1 : {r[30:0], 1'b1}};
    end
    r = {1'b0, a} - {17'h0_0000, o} - 33'(!f.carry);
    v = a[31] & !r[31];
    d = (v && f.saturate_enable) ? SAT_NEG : r[31:0];
    return {!r[32], f.arith_wrap_flag | v, d};
  endfunction : model

  // one instruction; the operand stands only in the cycle the step reads it,
  // scrambled before and after so a late or early sample shows up
  task op(input logic [15:0] w, input logic [15:0] o);
    logic [33:0] e;
    #1 e = model(w[15:8], acc_q, o, flags_q);
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr_word  <= w;
    mem_rdata   <= ~o;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1 chk({16'h0000, mem_req_q.addr}, {16'h0000, w[7] ? aux_v : {page_v, w[6:0]}});
    chk({30'h0000_0000, mem_req_q.rd, instr_ready_q}, 32'h0000_0002);
    @(posedge ref_clk) mem_rdata <= o;
    @(posedge ref_clk) mem_rdata <= ~o;
    #1 chk(acc_q, e[31:0]);
    chk({30'h0000_0000, flags_q[1:0]}, {30'h0000_0000, e[32], e[33]});
    chk({30'h0000_0000, done_q, instr_ready_q}, 32'h0000_0003);
  endtask : op

  task tally_and_finish;
    if (n_fail == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  // hang guard, far beyond the roughly eight hundred cycles the run needs
  initial
  begin
    #500_000;
    n_fail++;
    tally_and_finish();
  end

  initial
  begin
    ref_clk = 1'b0;
    rst_b = 1'b0;
    clk_en = 1'b1;
    bus_req = '0;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    mem_rdata = 16'h0000;
    n_fail = 0;
    tests_run = 0;
    void'($urandom(68276));
    page_v = 9'($urandom);
    aux_v = 16'($urandom);
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    // reset values, unmapped place last
    foreach (ofs[i])
    begin
      rd(ofs[i], rd_v);
      chk(rd_v, 32'h0000_0000);
    end
    // sequencer idle and ready after reset
    rd(OFS_STATE, rd_v);
    chk(rd_v, {28'h000_0000, ST_IDLE, OP_SUBTRACT_WITH_BORROW, 1'b1});
    wr(OFS_PAGE, {23'h00_0000, page_v});
    wr(OFS_AUX, {16'h0000, aux_v});
    // pending borrow: 6 - 6 - 1 borrows again
    setup(32'h0000_0006, 4'h0);
    op({OPC_SUBTRACT_WITH_BORROW, 8'h05}, 16'h0006);
    chk({flags_q.carry, acc_q[30:0]}, 32'h7FFF_FFFF);
    // negative wrap with and without clamping, then a step that must not clamp
    for (int s = 0; s < 2; s++)
    begin
      setup(SAT_NEG, {1'b0, s[0], 2'b01});
      op({OPC_SUBTRACT_WITH_BORROW, 8'h81}, 16'h0001);
      op({OPC_CONDITIONAL_SUBTRACT_STEP, 8'h81}, 16'hFFFF);
    end
    // random operands, modes and addressing, pairs back to back
    repeat (40)
    begin
      setup($urandom, 4'($urandom));
      repeat (2) op({$urandom_range(0, 1) ? OPC_SUBTRACT_WITH_BORROW : OPC_CONDITIONAL_SUBTRACT_STEP, 8'($urandom)}, 16'($urandom));
    end
    // division, last one with a pre-shifted short dividend
    for (int k = 0; k < 4; k++)
    begin
      dvd = 16'($urandom);
      dvs = 16'($urandom_range(1, 32767));
      sh = 0;
      if (k == 3)
      begin
        dvd = 16'h0007;
        dvs = 16'h0003;
        sh = 12;
      end
      setup({16'h0000, dvd} << sh, {k[0], 3'b000});
      repeat (16 - sh) op({OPC_CONDITIONAL_SUBTRACT_STEP, 8'h80}, dvs);
      chk(acc_q, {dvd % dvs, dvd / dvs});
    end
    // illegal opcode raises its status bit and the interrupt
    wr(OFS_IRQ_STAT, 32'h0000_0007);
    wr(OFS_IRQ_MASK, 32'h0000_0004);
    #1 chk({31'h0000_0000, irq_q}, 32'h0000_0000);
    @(posedge ref_clk) instr_valid <= 1'b1;
    instr_word <= 16'h0000;
    @(posedge ref_clk) instr_valid <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk({31'h0000_0000, irq_q}, 32'h0000_0001);
    rd(OFS_IRQ_STAT, rd_v);
    chk(rd_v, 32'h0000_0004);
    wr(OFS_IRQ_MASK, 32'h0000_0000);
    #1 chk({31'h0000_0000, irq_q}, 32'h0000_0000);
    wr(OFS_IRQ_STAT, 32'h0000_0004);
    rd(OFS_IRQ_STAT, rd_v);
    chk(rd_v, 32'h0000_0000);
    // a write while frozen is lost
    @(posedge ref_clk) clk_en <= 1'b0;
    wr(OFS_ACC, 32'h1234_5678);
    @(posedge ref_clk) clk_en <= 1'b1;
    rd(OFS_ACC, rd_v);
    chk(rd_v, 32'h0001_0002);
    tally_and_finish();
  end
endmodule : subtract_borrow_conditional_alu_test
